// ### src/uart_status_control.sv
// holds the serial status/control core: tx/rx engines, queues, flags and irq
// assumes serial_rx_pin is asynchronous and software uses the plain register port
// What this block does
// - infrared on: polarity bit sets idle level directly
// - break sends start, twelve zeros, stop; self-clears
// - tx enable drives pin; clear aborts, flushes
// - tx full flag reads queue full
// - tx empty needs shifter and queue empty
// - select 11: irq when queue reaches four
// - select 10: irq when queue reaches three
// - select 0x: irq on every received character
// - address detect in nine-bit mode keeps ninth-bit-one characters only
// - idle flag high while receiver not busy
// - parity flag follows head character
// - framing flag follows head character
// - overrun set on overflow; software only clears
// - clearing overrun flushes rx queue and shifter
// - data available while rx queue nonempty
// - infrared off: polarity bit inverts idle level
// - rx and tx queues four deep
module uart_status_control (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        serial_rx_pin,
  output logic             serial_tx_pin,
  output logic             serial_tx_oe_n,
  output logic             irq
);
  typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_START = 2'b01, TX_DATA = 2'b11,
                            TX_STOP = 2'b10} tx_state_type;
  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b11,
                            RX_STOP = 2'b10} rx_state_type;
  // ----------------------------------------
  // software state
  // ----------------------------------------
  logic        txinv_ff;    // tx_polarity_invert
  logic        brk_ff;      // tx_break_request
  logic        txen_ff;     // tx_enable_bit
  logic [1:0]  rxsel_ff;    // rx_irq_select
  logic        address_detect_enable_ff;    // address_detect_enable
  logic        overrun_flag_ff;     // overrun_flag
  logic [3:0]  ctrl_ff;     // infrared, nine-bit, parity enable, odd parity
  logic [15:0] div_ff;      // oversample divider
  localparam int IRQ_BITS = uart_sc_pkg::IRQ_W;
  logic [IRQ_BITS-1:0] ist_ff; // sticky events
  logic [IRQ_BITS-1:0] ien_ff; // event enables
  logic [15:0] rdata_ff;    // read answer
  // ----------------------------------------
  // queues and tick
  // ----------------------------------------
  fifo_if txq ();
  fifo_if rxq ();
  logic tick; // sixteen per bit
  char_fifo u_txq (.clk_sys(clk_sys), .reset_n(reset_n), .q(txq)); // storage
  char_fifo u_rxq (.clk_sys(clk_sys), .reset_n(reset_n), .q(rxq));
  baud_tick u_tick (.clk_sys(clk_sys), .reset_n(reset_n), .divisor(div_ff), .tick(tick));
  // ----------------------------------------
  // register decode
  // ----------------------------------------
  wire logic wr_sta  = reg_wr && (reg_addr == uart_sc_pkg::ADDR_STATUS);
  wire logic wr_ctl  = reg_wr && (reg_addr == uart_sc_pkg::ADDR_CONTROL);
  wire logic wr_tx   = reg_wr && (reg_addr == uart_sc_pkg::ADDR_TXDATA);
  wire logic rd_rx   = reg_rd && (reg_addr == uart_sc_pkg::ADDR_RXDATA);
  wire logic wr_ien  = reg_wr && (reg_addr == uart_sc_pkg::ADDR_IRQ_EN);
  wire logic wr_iclr = reg_wr && (reg_addr == uart_sc_pkg::ADDR_IRQ_CLR);
  wire logic nine    = ctrl_ff[uart_sc_pkg::C_NINE];
  wire logic tx_full = (txq.level == uart_sc_pkg::LEVEL_FULL);
  wire logic rx_full = (rxq.level == uart_sc_pkg::LEVEL_FULL);
  wire logic rx_da   = (rxq.level != '0);
  // overrun falls only by software writing zero over a set flag
  wire logic overrun_flag_clr = wr_sta && overrun_flag_ff && !reg_wdata[uart_sc_pkg::B_OVERRUN_FLAG];
  // ----------------------------------------
  // transmitter state
  // ----------------------------------------
  tx_state_type tx_st_ff;
  logic [3:0]  tx_os_ff;   // oversample count
  logic [3:0]  tx_bit_ff;  // bits left
  logic [9:0]  tx_sh_ff;   // data plus optional parity
  logic        tx_brk_ff;  // current frame is break
  logic        tx_line_ff; // unencoded line, 1 = mark
  wire  logic  tx_busy  = (tx_st_ff != TX_IDLE);
  wire  logic  tx_bitend = tick && (tx_os_ff == uart_sc_pkg::OSR_LAST);
  wire  logic  tx_go    = txen_ff && !tx_busy && (brk_ff || txq.level != '0);
  wire  logic  tx_take  = tx_go && !brk_ff;
  wire  logic  tx_par   = ^txq.rdata[7:0] ^ ctrl_ff[uart_sc_pkg::C_PARODD];
  wire  logic  tx_extra = nine || ctrl_ff[uart_sc_pkg::C_PAREN];
  wire  logic [9:0] tx_load = nine ? {1'b1, txq.rdata[8:0]} : {1'b1, tx_par, txq.rdata[7:0]};
  wire  logic  brk_done = tx_busy && tx_brk_ff && (tx_st_ff == TX_STOP) && tx_bitend;
  assign txq.push  = wr_tx && !tx_full && txen_ff;
  assign txq.pop   = tx_take;
  assign txq.flush = !txen_ff;
  assign txq.wdata = {2'h0, reg_wdata[8:0]};
  // one clocked process for the whole transmitter; break length comes from the package, data counts are fixed at 8 or 9
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tx_st_ff <= TX_IDLE;
      tx_os_ff <= '0;
      tx_bit_ff <= '0;
      tx_sh_ff <= '0;
      tx_brk_ff <= 1'b0;
      tx_line_ff <= 1'b1;
    end else if (!txen_ff) begin // abort on disable
      tx_st_ff <= TX_IDLE;
      tx_line_ff <= 1'b1;
    end else begin
      tx_os_ff <= tick ? tx_os_ff + 4'h1 : tx_os_ff;
      unique case (tx_st_ff)
        TX_IDLE: begin
          if (tx_go) begin
            tx_st_ff  <= TX_START;
            tx_os_ff  <= '0;
            tx_brk_ff <= brk_ff;
            tx_sh_ff  <= brk_ff ? '0 : tx_load;
            tx_bit_ff <= brk_ff ? uart_sc_pkg::BRK_ZEROS : (tx_extra ? 4'h9 : 4'h8);
            tx_line_ff <= 1'b0;
          end
        end
        TX_START: if (tx_bitend) begin
          tx_st_ff <= TX_DATA;
          tx_line_ff <= tx_sh_ff[0];
          tx_sh_ff <= {1'b0, tx_sh_ff[9:1]};
          tx_bit_ff <= tx_bit_ff - 4'h1;
        end
        TX_DATA: if (tx_bitend) begin
          if (tx_bit_ff == '0) begin
            tx_st_ff <= TX_STOP;
            tx_line_ff <= 1'b1;
          end else begin
            tx_line_ff <= tx_sh_ff[0];
            tx_sh_ff <= {1'b0, tx_sh_ff[9:1]};
            tx_bit_ff <= tx_bit_ff - 4'h1;
          end
        end
        TX_STOP: if (tx_bitend) begin
          tx_st_ff <= TX_IDLE;
        end
      endcase
    end
  end
  // infrared: short pulse for each zero bit, otherwise the polarity bit level
  wire logic ir_on   = ctrl_ff[uart_sc_pkg::C_INFRARED_CODEC_ENABLE];
  wire logic ir_puls = !tx_line_ff && (tx_os_ff < uart_sc_pkg::IR_PULSE);
  wire logic ir_line = ir_puls ? !txinv_ff : txinv_ff;
  wire logic plain   = tx_line_ff ^ txinv_ff;
  logic pin_ff; // registered pin drive
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pin_ff <= 1'b1;
    end else begin
      pin_ff <= ir_on ? ir_line : plain;
    end
  end
  assign serial_tx_pin  = pin_ff;
  assign serial_tx_oe_n = !txen_ff; // port owns pin when off
  // ----------------------------------------
  // receiver: sync, then oversampled engine
  // ----------------------------------------
  logic rx_s1_ff;
  logic rx_s2_ff;
  logic rx_prev_ff; // synced line one cycle back; idle high so reset makes no edge
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rx_s1_ff   <= 1'b1;
      rx_s2_ff   <= 1'b1;
      rx_prev_ff <= 1'b1;
    end else begin
      rx_s1_ff   <= serial_rx_pin;
      rx_s2_ff   <= rx_s1_ff;
      rx_prev_ff <= rx_s2_ff;
    end
  end
  rx_state_type rx_st_ff;
  logic [3:0] rx_os_ff;
  logic [3:0] rx_bit_ff;
  logic [9:0] rx_sh_ff;
  wire logic rx_mid = tick && (rx_os_ff == uart_sc_pkg::OSR_MID);
  wire logic rx_nbits = nine || ctrl_ff[uart_sc_pkg::C_PAREN];
  // the last bit lands in sh[9]: first bit sits at sh[1] for nine bits, sh[2] for eight
  wire logic [9:0] rx_word = rx_nbits ? {1'b0, rx_sh_ff[9:1]} : {2'b00, rx_sh_ff[9:2]};
  wire logic rx_parity_error_flag = ctrl_ff[uart_sc_pkg::C_PAREN] && !nine &&
                       (^rx_word[8:0] != ctrl_ff[uart_sc_pkg::C_PARODD]);
  wire logic rx_done = (rx_st_ff == RX_STOP) && rx_mid;
  wire logic rx_keep = !(address_detect_enable_ff && nine && !rx_word[8]);
  wire logic rx_xfer = rx_done && rx_keep && !overrun_flag_ff && !rx_full;
  wire logic rx_ovf  = rx_done && rx_keep && !overrun_flag_ff && rx_full;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rx_st_ff <= RX_IDLE;
      rx_os_ff <= '0;
      rx_bit_ff <= '0;
      rx_sh_ff <= '0;
    end else if (overrun_flag_clr) begin // shifter back to empty
      rx_st_ff <= RX_IDLE;
      rx_os_ff <= '0;
    end else begin
      rx_os_ff <= tick ? rx_os_ff + 4'h1 : rx_os_ff;
      unique case (rx_st_ff)
        // start on a falling edge only: a low stop bit must not restart the frame
        RX_IDLE: if (!rx_s2_ff && rx_prev_ff) begin
          rx_st_ff <= RX_START;
          rx_os_ff <= '0;
        end
        RX_START: if (rx_mid) begin
          rx_st_ff  <= rx_s2_ff ? RX_IDLE : RX_DATA; // glitch rejection
          rx_bit_ff <= rx_nbits ? 4'h9 : 4'h8;
        end
        RX_DATA: if (rx_mid) begin
          rx_sh_ff  <= {rx_s2_ff, rx_sh_ff[9:1]};
          rx_bit_ff <= rx_bit_ff - 4'h1;
          if (rx_bit_ff == 4'h1) begin
            rx_st_ff <= RX_STOP;
          end
        end
        RX_STOP: if (rx_mid) begin
          rx_st_ff <= RX_IDLE;
        end
      endcase
    end
  end
  assign rxq.push  = rx_xfer;
  assign rxq.pop   = rd_rx && rx_da;
  assign rxq.flush = overrun_flag_clr;
  assign rxq.wdata = {rx_parity_error_flag, !rx_s2_ff, rx_word[8:0]};
  wire logic rx_idle = (rx_st_ff == RX_IDLE);
  // receive interrupt condition by level reached on this transfer
  wire logic [2:0] lvl_after = rxq.level + 3'h1;
  wire logic rx_evt = rx_xfer && (rxsel_ff[1] ?
                      (lvl_after == (rxsel_ff[0] ? uart_sc_pkg::LEVEL_FULL
                                                 : uart_sc_pkg::LEVEL_3Q)) : 1'b1);
  wire logic [IRQ_BITS-1:0] evt = {rxq.wdata[9] && rx_xfer, rx_ovf, rx_evt};
  // ----------------------------------------
  // register writes and flags
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      txinv_ff <= 1'b0;
      brk_ff   <= 1'b0;
      txen_ff  <= 1'b0;
      rxsel_ff <= '0;
      address_detect_enable_ff <= 1'b0;
      overrun_flag_ff  <= 1'b0;
      ctrl_ff  <= '0;
      div_ff   <= uart_sc_pkg::RESET_DIV;
      ien_ff   <= '0;
    end else begin
      if (wr_sta) begin
        txinv_ff <= reg_wdata[uart_sc_pkg::B_TXINV];
        txen_ff  <= reg_wdata[uart_sc_pkg::B_TXEN];
        rxsel_ff <= reg_wdata[uart_sc_pkg::B_RXSELH:uart_sc_pkg::B_RXSELL];
        address_detect_enable_ff <= reg_wdata[uart_sc_pkg::B_ADDRESS_DETECT_ENABLE];
      end
      // completion clear loses to a fresh software set
      if (wr_sta && reg_wdata[uart_sc_pkg::B_BRK]) begin
        brk_ff <= 1'b1;
      end else if (brk_done || !txen_ff) begin
        brk_ff <= 1'b0;
      end
      // overflow wins over a clear in the same cycle
      if (rx_ovf) begin
        overrun_flag_ff <= 1'b1;
      end else if (overrun_flag_clr) begin
        overrun_flag_ff <= 1'b0;
      end
      if (wr_ctl) begin
        ctrl_ff <= reg_wdata[3:0];
      end
      if (wr_ctl && reg_wdata[15:4] != '0) begin
        div_ff <= {4'h0, reg_wdata[15:4]};
      end
      if (wr_ien) begin
        ien_ff <= reg_wdata[IRQ_BITS-1:0];
      end
    end
  end
  // sticky events: set beats clear
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ist_ff <= '0;
    end else begin
      ist_ff <= (ist_ff & ~(wr_iclr ? reg_wdata[IRQ_BITS-1:0] : '0)) | evt;
    end
  end
  assign irq = |(ist_ff & ien_ff);
  // ----------------------------------------
  // read mux, answer next cycle
  // ----------------------------------------
  logic [15:0] sta_word;
  always_comb begin
    sta_word = '0;
    sta_word[uart_sc_pkg::B_TXINV] = txinv_ff;
    sta_word[uart_sc_pkg::B_BRK]   = brk_ff;
    sta_word[uart_sc_pkg::B_TXEN]  = txen_ff;
    sta_word[uart_sc_pkg::B_TXBF]  = tx_full;
    sta_word[uart_sc_pkg::B_TX_ALL_EMPTY]  = !tx_busy && (txq.level == '0);
    sta_word[uart_sc_pkg::B_RXSELH:uart_sc_pkg::B_RXSELL] = rxsel_ff;
    sta_word[uart_sc_pkg::B_ADDRESS_DETECT_ENABLE] = address_detect_enable_ff;
    sta_word[uart_sc_pkg::B_IDLE]  = rx_idle;
    sta_word[uart_sc_pkg::B_PARITY_ERROR_FLAG]  = rx_da && rxq.rdata[10];
    sta_word[uart_sc_pkg::B_FRAMING_ERROR_FLAG]  = rx_da && rxq.rdata[9];
    sta_word[uart_sc_pkg::B_OVERRUN_FLAG]  = overrun_flag_ff;
    sta_word[uart_sc_pkg::B_RXDA]  = rx_da;
  end
  wire logic [15:0] rd_mux =
      (reg_addr == uart_sc_pkg::ADDR_STATUS)  ? sta_word :
      (reg_addr == uart_sc_pkg::ADDR_CONTROL) ? {div_ff[11:0], ctrl_ff} :
      (reg_addr == uart_sc_pkg::ADDR_RXDATA)  ? {7'h00, rxq.rdata[8:0]} :
      (reg_addr == uart_sc_pkg::ADDR_IRQ_ST)  ? {13'h0000, ist_ff} :
      (reg_addr == uart_sc_pkg::ADDR_IRQ_EN)  ? {13'h0000, ien_ff} : 16'h0000;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= reg_rd ? rd_mux : '0;
    end
  end
  assign reg_rdata = rdata_ff;
  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_tx_empty_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(sta_word[uart_sc_pkg::B_TX_ALL_EMPTY]) |-> $past(tx_st_ff == TX_STOP || !txen_ff))
    else $error("tx empty flag rose mid transfer");
  a_overrun_flush: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (overrun_flag_clr && !rx_ovf) |=> (rxq.level == '0 && !overrun_flag_ff))
    else $error("overrun clear did not flush");
  a_no_xfer_ovr: assert property (@(posedge clk_sys) disable iff (!reset_n)
    overrun_flag_ff |-> !rxq.push)
    else $error("transfer while overrun set");
  a_ovr_sets: assert property (@(posedge clk_sys) disable iff (!reset_n)
    rx_ovf |=> overrun_flag_ff)
    else $error("overflow lost");
  a_full_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (txq.level <= uart_sc_pkg::LEVEL_FULL) && (rxq.level <= uart_sc_pkg::LEVEL_FULL))
    else $error("queue level beyond depth");
  a_tx_disable: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !txen_ff |=> (txq.level == '0 && tx_st_ff == TX_IDLE))
    else $error("tx disable did not abort");
  a_data_avail: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(rxq.level != '0) |-> $past(rxq.push))
    else $error("data appeared without transfer");
  a_rx_irq_any: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (rx_xfer && !rxsel_ff[1]) |=> ist_ff[uart_sc_pkg::I_RX])
    else $error("rx event lost");
endmodule

// ### pkg/uart_sc_pkg.sv
// holds register offsets, bit positions, reset values and timing for the uart status block
// assumes a 200 MHz system clock and 16 samples per serial bit
package uart_sc_pkg;
  // ----------------------------------------
  // register offsets on the plain port
  // ----------------------------------------
  localparam logic [3:0] ADDR_STATUS  = 4'h0; // serial_status_control
  localparam logic [3:0] ADDR_CONTROL = 4'h1; // infrared / nine-bit / baud divider
  localparam logic [3:0] ADDR_TXDATA  = 4'h2; // write a character
  localparam logic [3:0] ADDR_RXDATA  = 4'h3; // read a character
  localparam logic [3:0] ADDR_IRQ_ST  = 4'h4; // sticky event bits
  localparam logic [3:0] ADDR_IRQ_EN  = 4'h5; // event enables
  localparam logic [3:0] ADDR_IRQ_CLR = 4'h6; // write one to clear
  // ----------------------------------------
  // status/control bit positions
  // ----------------------------------------
  localparam int B_TXINV  = 14;
  localparam int B_BRK    = 11;
  localparam int B_TXEN   = 10;
  localparam int B_TXBF   = 9;
  localparam int B_TX_ALL_EMPTY   = 8;
  localparam int B_RXSELH = 7;
  localparam int B_RXSELL = 6;
  localparam int B_ADDRESS_DETECT_ENABLE  = 5;
  localparam int B_IDLE   = 4;
  localparam int B_PARITY_ERROR_FLAG   = 3;
  localparam int B_FRAMING_ERROR_FLAG   = 2;
  localparam int B_OVERRUN_FLAG   = 1;
  localparam int B_RXDA   = 0;
  // control register bits
  localparam int C_INFRARED_CODEC_ENABLE   = 0;
  localparam int C_NINE   = 1;
  localparam int C_PAREN  = 2;
  localparam int C_PARODD = 3;
  // irq bits
  localparam int I_RX     = 0;
  localparam int I_OVR    = 1;
  localparam int I_ERR    = 2;
  localparam int IRQ_W    = 3;
  // ----------------------------------------
  // sizes and counts
  // ----------------------------------------
  localparam int          FIFO_DEPTH = 4;
  localparam int          PTR_W      = 2;
  localparam int          CNT_W      = 3;
  localparam logic [2:0]  LEVEL_FULL = 3'h4;
  localparam logic [2:0]  LEVEL_3Q   = 3'h3;
  localparam int          WORD_W     = 11; // data9, parity_error_flag, framing_error_flag
  localparam logic [3:0]  OSR_LAST   = 4'hf;
  localparam logic [3:0]  OSR_MID    = 4'h7;
  localparam logic [3:0]  BRK_ZEROS  = 4'hc;
  localparam logic [15:0] RESET_DIV  = 16'h0001;
  localparam logic [3:0]  IR_PULSE   = 4'h5; // 5/16 bit pulse window
endpackage

// ### pkg/fifo_if.sv
// holds the push/pop bundle between the core and its small queues
// assumes a single clock domain
interface fifo_if;
  logic                          push;  // write one word
  logic                          pop;   // drop the head word
  logic                          flush; // empty the queue
  logic [uart_sc_pkg::WORD_W-1:0] wdata; // word in
  logic [uart_sc_pkg::WORD_W-1:0] rdata; // head word, registered
  logic [uart_sc_pkg::CNT_W-1:0]  level; // words held
  modport owner (output push, pop, flush, wdata, input rdata, level);
  modport queue (input push, pop, flush, wdata, output rdata, level);
endinterface

// ### src/char_fifo.sv
// holds a four deep character queue with registered head word
// assumes the owner never pushes when full nor pops when empty
module char_fifo (
  input  wire logic clk_sys,
  input  wire logic reset_n,
  fifo_if.queue     q
);
  logic [uart_sc_pkg::WORD_W-1:0] mem_ff [uart_sc_pkg::FIFO_DEPTH]; // storage
  logic [uart_sc_pkg::PTR_W-1:0]  wr_ff;                            // write pointer
  logic [uart_sc_pkg::PTR_W-1:0]  rd_ff;                            // read pointer
  logic [uart_sc_pkg::CNT_W-1:0]  lvl_ff;                           // fill level
  logic [uart_sc_pkg::WORD_W-1:0] head_ff;                          // registered head
  wire  logic [uart_sc_pkg::PTR_W-1:0] nxt_rd = q.pop ? rd_ff + 1'b1 : rd_ff;
  // ----------------------------------------
  // pointers and level
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      lvl_ff <= '0;
    end else if (q.flush) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      lvl_ff <= '0;
    end else begin
      wr_ff  <= q.push ? wr_ff + 1'b1 : wr_ff;
      rd_ff  <= nxt_rd;
      lvl_ff <= lvl_ff + {2'h0, q.push} - {2'h0, q.pop};
    end
  end
  // storage has no reset; head word follows the read pointer
  always_ff @(posedge clk_sys) begin
    if (q.push) begin
      mem_ff[wr_ff] <= q.wdata;
    end
  end
  // head tracks a push into an empty queue too, so flags follow the top
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      head_ff <= '0;
    end else if (q.push && (nxt_rd == wr_ff)) begin
      head_ff <= q.wdata;
    end else begin
      head_ff <= mem_ff[nxt_rd];
    end
  end
  assign q.rdata = head_ff;
  assign q.level = lvl_ff;
endmodule

// ### src/baud_tick.sv
// holds the oversampling tick divider
// assumes the divider value is static while a character moves
module baud_tick (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic [15:0] divisor,
  output logic             tick
);
  logic [15:0] cnt_ff; // cycles left to next tick
  wire  logic  wrap = (cnt_ff == '0);
  // ----------------------------------------
  // down counter, reloads on wrap
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= wrap ? divisor : cnt_ff - 16'h0001;
    end
  end
  assign tick = wrap;
endmodule

// ### verification/uart_peer_model.sv
// serial peer: sends frames on the rx line, captures frames from the tx line
// assumes 32 system clocks per bit (reset divider) and an idle-high line
module uart_peer_model (
  input  wire logic clk_sys,
  input  wire logic serial_tx_pin,
  output logic      serial_rx_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT_CYC = 32; // clocks per serial bit
  initial serial_rx_pin = 1'b1;
  // ----------------------------------------
  // frame out: start, nb data bits lsb first, chosen stop level, idle bit
  // ----------------------------------------
  task automatic send(input logic [8:0] d, input int nb, input logic stop);
    serial_rx_pin <= 1'b0;
    repeat (BIT_CYC) @(posedge clk_sys);
    for (int i = 0; i < nb; i++) begin
      serial_rx_pin <= d[i];
      repeat (BIT_CYC) @(posedge clk_sys);
    end
    serial_rx_pin <= stop; // low stop forces a framing fault
    repeat (BIT_CYC) @(posedge clk_sys);
    serial_rx_pin <= 1'b1;
    repeat (BIT_CYC) @(posedge clk_sys);
  endtask
  // ----------------------------------------
  // frame in: samples mid-bit, returns after the last data bit
  // ----------------------------------------
  task automatic grab(output logic [7:0] d);
    @(negedge serial_tx_pin);
    repeat (BIT_CYC / 2) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge clk_sys);
      d[i] = serial_tx_pin;
    end
  endtask
endmodule

// ### verification/uart_status_control_tb_top.sv
// self-checking bench for the status/control core over its register port
// assumes the peer model above on the serial lines and reset divider
module uart_status_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0]  reg_addr  = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, v;
  logic        serial_rx_pin, serial_tx_pin, serial_tx_oe_n, irq;
  logic [7:0]  got, dq [$];
  int          mismatches = 0, total_checks = 0, thr [3] = '{4, 3, 1}, sel [3] = '{3, 2, 0};
  always #2.5 clk_sys = ~clk_sys;
  uart_status_control dut (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .serial_rx_pin(serial_rx_pin), .serial_tx_pin(serial_tx_pin),
    .serial_tx_oe_n(serial_tx_oe_n), .irq(irq));
  uart_peer_model peer (.clk_sys(clk_sys), .serial_tx_pin(serial_tx_pin),
    .serial_rx_pin(serial_rx_pin));
  // ----------------------------------------
  // register port and compare helpers
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    #1; // let the written register settle before the caller looks
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata; // data stand only in this cycle
  endtask
  // status image: idle receiver and chosen flags on top of the control bits
  function automatic logic [15:0] st(input logic [15:0] ctl, input logic [7:0] flg);
    return ctl | 16'h0010 | {8'h00, flg};
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // watchdog: whole run is well under 200 us
  initial begin
    #200us;
    mismatches++;
    stop_test();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'hfb5a6a45));
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(uart_sc_pkg::ADDR_STATUS, v); check(v, 16'h0110);
    rd(4'hf, v); check(v, 16'h0000);
    wr(uart_sc_pkg::ADDR_STATUS, 16'h0400);
    check({15'h0, serial_tx_oe_n}, 16'h0000);
    got = 8'($urandom);
    dq.push_back(got);
    fork
      peer.grab(got);
      wr(uart_sc_pkg::ADDR_TXDATA, {8'h00, dq[0]});
    join
    check({8'h00, got}, {8'h00, dq.pop_front()});
    repeat (80) @(posedge clk_sys);
    rd(uart_sc_pkg::ADDR_STATUS, v); check(v, st(16'h0400, 8'h00) | 16'h0100);
    for (int i = 0; i < 6; i++) wr(uart_sc_pkg::ADDR_TXDATA, 16'($urandom) & 16'h00ff);
    rd(uart_sc_pkg::ADDR_STATUS, v); check(v, st(16'h0600, 8'h00));
    wr(uart_sc_pkg::ADDR_STATUS, 16'h0000); // abort the queued characters
    rd(uart_sc_pkg::ADDR_STATUS, v); check(v, st(16'h0100, 8'h00));
    wr(uart_sc_pkg::ADDR_STATUS, 16'h4400); // inverted idle, plain coding
    repeat (4) @(posedge clk_sys);
    check({15'h0, serial_tx_pin}, 16'h0000);
    wr(uart_sc_pkg::ADDR_CONTROL, 16'h0011); // infrared coding on
    repeat (4) @(posedge clk_sys);
    check({15'h0, serial_tx_pin}, 16'h0001);
    wr(uart_sc_pkg::ADDR_CONTROL, 16'h0010);
    wr(uart_sc_pkg::ADDR_STATUS, 16'h0c00); // break frame, plain idle high
    repeat (200) @(posedge clk_sys);
    check({15'h0, serial_tx_pin}, 16'h0000);
    rd(uart_sc_pkg::ADDR_STATUS, v); check(v, st(16'h0c00, 8'h00));
    repeat (400) @(posedge clk_sys);
    rd(uart_sc_pkg::ADDR_STATUS, v); check(v, st(16'h0500, 8'h00));
    wr(uart_sc_pkg::ADDR_STATUS, 16'h0000);
    rd(uart_sc_pkg::ADDR_STATUS, v); check(v, st(16'h0100, 8'h00));
    check({15'h0, serial_tx_oe_n}, 16'h0001);
    wr(uart_sc_pkg::ADDR_IRQ_EN, 16'h0001);
    // receive threshold modes, overrun on the full queue
    for (int m = 0; m < 3; m++) begin
      wr(uart_sc_pkg::ADDR_STATUS, 16'(sel[m] << 6));
      wr(uart_sc_pkg::ADDR_IRQ_CLR, 16'h0007);
      for (int k = 1; k <= thr[m]; k++) begin
        dq.push_back(8'($urandom));
        peer.send({1'b0, dq[$]}, 8, 1'b1);
        check({15'h0, irq}, {15'h0, k == thr[m]});
      end
      if (thr[m] == 4) begin
        peer.send(9'h055, 8, 1'b1);
        rd(uart_sc_pkg::ADDR_STATUS, v); check(v, st(16'h01c0, 8'h03));
        wr(uart_sc_pkg::ADDR_STATUS, 16'h00c0);
        rd(uart_sc_pkg::ADDR_STATUS, v); check(v, st(16'h01c0, 8'h00));
        dq.delete();
      end
      while (dq.size() > 0) begin
        rd(uart_sc_pkg::ADDR_RXDATA, v); check(v & 16'h00ff, {8'h00, dq.pop_front()});
      end
    end
    // error flags follow the head character
    wr(uart_sc_pkg::ADDR_CONTROL, 16'h0014);
    got = 8'($urandom);
    fork
      peer.send({~^got, got}, 9, 1'b1);
      begin
        repeat (100) @(posedge clk_sys);
        rd(uart_sc_pkg::ADDR_STATUS, v); check(v & 16'h0010, 16'h0000);
      end
    join
    peer.send({^got, got}, 9, 1'b0);
    rd(uart_sc_pkg::ADDR_STATUS, v); check(v, st(16'h0100, 8'h09));
    rd(uart_sc_pkg::ADDR_RXDATA, v); check(v & 16'h00ff, {8'h00, got});
    rd(uart_sc_pkg::ADDR_STATUS, v); check(v, st(16'h0100, 8'h05));
    rd(uart_sc_pkg::ADDR_RXDATA, v);
    // address detect keeps only ninth-bit-one characters
    wr(uart_sc_pkg::ADDR_CONTROL, 16'h0012);
    wr(uart_sc_pkg::ADDR_STATUS, 16'h0020);
    peer.send({1'b0, got}, 9, 1'b1);
    peer.send({1'b1, ~got}, 9, 1'b1);
    rd(uart_sc_pkg::ADDR_STATUS, v); check(v, st(16'h0120, 8'h01));
    rd(uart_sc_pkg::ADDR_RXDATA, v); check(v, {7'h00, 1'b1, ~got});
    rd(uart_sc_pkg::ADDR_STATUS, v); check(v, st(16'h0120, 8'h00));
    stop_test();
  end
endmodule
